// *** bench/acs_core_model.sv ***
/*
 Behavioural model of the analog sample-and-hold and successive-approximation core.
 Assumes the sequencer's start and sample outputs come from the same clock.
*/
`timescale 1ns/1ns

module acs_core_model (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic conv_start,
	input wire logic sample_en,
	input wire logic [11:0] level,
	output logic [11:0] core_result
);
	logic busy_r;
	logic busy_nxt;

	always_comb begin
		busy_nxt = busy_r;
		if (conv_start) begin
			busy_nxt = 1'b1;
		end else if (sample_en) begin
			busy_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			busy_r <= 1'b0;
		end else begin
			busy_r <= busy_nxt;
		end
	end

	// Outside a conversion the held value is gone, so its inverse is shown.
	assign core_result = (busy_r | conv_start) ? level : ~level;
endmodule

// *** bench/tb_acs_top.sv ***
/*
 Self-checking bench of the converter sequencer with its analog core model.
 Assumes acs_defs.svh on the include path and the core model compiled first.
*/
`timescale 1ns/1ns
`include "acs_defs.svh"

`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin fails++; \
	$display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end

module tb_acs_top;
	typedef struct {
		logic [7:0] tim;
		logic [11:0] lvl;
		int rat;
		int dly;
		logic [7:0] hi;
		logic [7:0] lo;
	} acs_row_s;

	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [7:0] wr_data = 8'h00;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic trig_ccp = 1'b0;
	logic [3:0] capture_mode_field = 4'h0;
	logic trig_charge_time_unit = 1'b0;
	logic charge_time_trigger_bit = 1'b0;
	logic trig_tmr1 = 1'b0;
	logic trig_rtc = 1'b0;
	logic [23:0] port_pins = 24'h000000;
	logic [11:0] level = 12'h000;
	logic [7:0] rd_data;
	logic [23:0] port_read;
	logic [11:0] core_result;
	logic [4:0] pos_channel_select;
	logic [2:0] neg_channel_select;
	logic [1:0] pos_reference_select;
	logic neg_reference_select;
	logic timer_clear, sample_en, conv_start, conv_bit_tick, conv_done_irq_flag;
	int fails = 0;
	int samples_checked = 0;
	acs_row_s rows [8];

	acs_top dut (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
		.rd_en(rd_en), .rd_data(rd_data), .trig_ccp(trig_ccp),
		.capture_mode_field(capture_mode_field), .trig_charge_time_unit(trig_charge_time_unit),
		.charge_time_trigger_bit(charge_time_trigger_bit), .trig_tmr1(trig_tmr1),
		.trig_rtc(trig_rtc), .timer_clear(timer_clear), .port_pins(port_pins),
		.port_read(port_read), .core_result(core_result), .sample_en(sample_en),
		.conv_start(conv_start), .conv_bit_tick(conv_bit_tick),
		.pos_channel_select(pos_channel_select), .neg_channel_select(neg_channel_select),
		.pos_reference_select(pos_reference_select),
		.neg_reference_select(neg_reference_select),
		.conv_done_irq_flag(conv_done_irq_flag));

	acs_core_model core (.clk_sys(clk_sys), .rst(rst), .conv_start(conv_start),
		.sample_en(sample_en), .level(level), .core_result(core_result));

	always #10 clk_sys = ~clk_sys;

	// ----------------------------------------------------------------
	// Bus and measurement tasks
	// ----------------------------------------------------------------
	task automatic step();
		@(posedge clk_sys);
		#1;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk_sys);
		wr_en <= 1'b0;
	endtask

	task automatic rdc(input logic [3:0] a, input logic [7:0] ex, input string nm);
		@(posedge clk_sys);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk_sys);
		rd_en <= 1'b0;
		#1;
		`CHK(nm, ex, rd_data)
	endtask

	task automatic wait_hi(input bit on_start, output int n);
		n = 0;
		while ((on_start ? conv_start : sample_en) !== 1'b1 && n < 5000) begin
			step();
			n++;
		end
	endtask

	// Called at the edge that takes the go write; measures one whole conversion.
	task automatic conv_check(input int r, input int dly);
		int n, c, cnt, last;
		c = 0;
		cnt = 0;
		last = 0;
		wait_hi(1'b1, n);
		`CHK("start_delay", dly, n)
		while (sample_en !== 1'b1 && c < 20000) begin
			if (conv_bit_tick === 1'b1) begin
				if (cnt > 0) `CHK("tick_gap", r, c - last)
				cnt++;
				last = c;
			end
			step();
			c++;
		end
		`CHK("tick_count", 14, cnt)
		`CHK("recovery", 1'b1, (c - last >= 2 * r) && (c - last <= 2 * r + 2))
	endtask

	task automatic pulse(input int src, input logic [3:0] mode, input logic tbit);
		@(posedge clk_sys);
		capture_mode_field <= mode;
		charge_time_trigger_bit <= tbit;
		case (src)
			0: trig_ccp <= 1'b1;
			1: trig_charge_time_unit <= 1'b1;
			2: trig_tmr1 <= 1'b1;
			default: trig_rtc <= 1'b1;
		endcase
		@(posedge clk_sys);
		{trig_ccp, trig_charge_time_unit, trig_tmr1, trig_rtc} <= 4'h0;
		#1;
		`CHK("timer_clear", src == 0 && mode == 4'hb, timer_clear)
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge clk_sys);
		fails++;
		final_report();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		int n;
		// The clock never changes during a run, and the RC rows stand in for sleep use.
		rows = '{'{8'h80, 12'habc, 2, 4, 8'h0a, 8'hbc}, '{8'h14, 12'h5e7, 4, 16, 8'h5e, 8'h70},
			'{8'h81, 12'hfff, 8, 4, 8'h0f, 8'hff}, '{8'h15, 12'h000, 16, 64, 8'h00, 8'h00},
			'{8'h02, 12'h801, 32, 4, 8'h80, 8'h10}, '{8'h86, 12'h7ff, 64, 4, 8'h07, 8'hff},
			'{8'h03, 12'h246, 200, 4, 8'h24, 8'h60}, '{8'h97, 12'h9d3, 200, 800, 8'h09, 8'hd3}};
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		for (int a = 2; a <= 8; a++) rdc(4'(a), 8'h00, "reset_value");
		wr(4'h2, 8'h03);
		rdc(4'h2, 8'h01, "go_with_enable");
		wr(4'h0, 8'h5a);
		wr(4'h1, 8'ha5);
		rdc(4'h0, 8'h5a, "res_high_sw");
		rdc(4'h1, 8'ha5, "res_low_sw");
		wr(4'h5, 8'ha5);
		wr(4'h6, 8'h5a);
		wr(4'h7, 8'hff);
		@(posedge clk_sys);
		port_pins <= 24'hffffff;
		repeat (4) step();
		`CHK("port_read", 24'h00a55a, port_read)
		@(posedge clk_sys);
		port_pins <= 24'h0f0f0f;
		repeat (4) step();
		`CHK("port_read", 24'h00050a, port_read)
		for (int i = 0; i < 8; i++) begin
			wr(4'h4, rows[i].tim);
			level <= rows[i].lvl;
			wr(4'h2, 8'h03);
			conv_check(rows[i].rat, rows[i].dly);
			rdc(4'h2, 8'h01, "go_cleared");
			rdc(4'h0, rows[i].hi, "res_high");
			rdc(4'h1, rows[i].lo, "res_low");
			`CHK("done_flag", 1'b1, conv_done_irq_flag)
			wr(4'h8, 8'h01);
			#1;
			`CHK("done_flag_clear", 1'b0, conv_done_irq_flag)
		end

		// Divider change in mid-conversion, on the highest channel.
		wr(4'h4, 8'h86);
		wr(4'h2, 8'hfd);
		wr(4'h2, 8'hff);
		fork
			conv_check(64, 4);
			begin
				wait_hi(1'b1, n);
				wr(4'h4, 8'h80);
			end
		join
		`CHK("channel", 5'h1f, pos_channel_select)
		rdc(4'h0, 8'h09, "res_high_ch");
		wr(4'h2, 8'h01);
		wr(4'h8, 8'h01);

		for (int s = 0; s < 4; s++) begin
			wr(4'h3, 8'(s << 6));
			pulse(s, 4'hb, 1'b1);
			rdc(4'h2, 8'h03, "trigger_go");
			wait_hi(1'b1, n);
			wait_hi(1'b0, n);
		end
		wr(4'h3, 8'h00);
		pulse(0, 4'ha, 1'b1);
		rdc(4'h2, 8'h01, "ccp_wrong_mode");
		wr(4'h3, 8'h40);
		pulse(1, 4'hb, 1'b0);
		rdc(4'h2, 8'h01, "charge_time_unit_bit_clear");
		wr(4'h3, 8'h00);
		wr(4'h2, 8'h00);
		pulse(0, 4'hb, 1'b1);
		rdc(4'h2, 8'h00, "disabled_trigger");
		wr(4'h2, 8'h01);
		wr(4'h3, 8'h3d);
		step();
		`CHK("neg_channel", 3'h5, neg_channel_select)
		`CHK("pos_reference", 2'h3, pos_reference_select)
		`CHK("neg_reference", 1'b1, neg_reference_select)
		wr(4'h3, 8'h00);

		wr(4'h0, 8'h5a);
		wr(4'h1, 8'ha5);
		wr(4'h4, 8'h86);
		wr(4'h2, 8'h03);
		wait_hi(1'b1, n);
		repeat (100) step();
		wr(4'h2, 8'h01);
		wait_hi(1'b0, n);
		`CHK("abort_recovery", 1'b1, n >= 128 && n <= 131)
		rdc(4'h2, 8'h01, "abort_go");
		rdc(4'h0, 8'h5a, "abort_res_high");
		rdc(4'h1, 8'ha5, "abort_res_low");

		wr(4'h2, 8'h03);
		wait_hi(1'b1, n);
		repeat (10) step();
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		step();
		`CHK("reset_sample", 1'b0, sample_en)
		rdc(4'h2, 8'h00, "reset_main");
		rdc(4'h0, 8'h5a, "reset_res_high");
		rdc(4'h1, 8'ha5, "reset_res_low");
		final_report();
	end
endmodule

// *** core/acs_defs.svh ***
/*
 Constants of the converter sequencer: register offsets, fields, reset values, timing.
 Assumes a 50 MHz system clock and a byte-wide register port.
*/
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH

`define ACS_OFS_RES_HI 4'h0
`define ACS_OFS_RES_LO 4'h1
`define ACS_OFS_CTL_MAIN 4'h2
`define ACS_OFS_CTL_REF 4'h3
`define ACS_OFS_CTL_TIM 4'h4
`define ACS_OFS_ANA_LO 4'h5
`define ACS_OFS_ANA_MID 4'h6
`define ACS_OFS_ANA_HI 4'h7
`define ACS_OFS_STATUS 4'h8

`define ACS_BIT_EN 0
`define ACS_BIT_GO 1
`define ACS_BIT_DONE 0
`define ACS_RST_CTL 8'h00
`define ACS_RST_ANA 24'h000000

`define ACS_TRIG_CCP 2'h0
`define ACS_TRIG_CHARGE_TIME_UNIT 2'h1
`define ACS_TRIG_TMR1 2'h2
`define ACS_TRIG_RTC 2'h3
`define ACS_CCP_MODE_TRIG 4'hb

`define ACS_CLK_PERIOD_NS 20
`define ACS_RC_TAD_NS 4000
`define ACS_RC_TAD_CYC (`ACS_RC_TAD_NS / `ACS_CLK_PERIOD_NS)
`define ACS_INSTR_NS 80
`define ACS_INSTR_CYC ((`ACS_INSTR_NS + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS)
`define ACS_CONV_TADS 14
`define ACS_RECOV_TADS 2

`endif

// *** core/acs_pkg.sv ***
/*
 Types of the converter sequencer.
 Assumes nothing of its surroundings.
*/
package acs_pkg;

	typedef enum logic [2:0] {
		st_sample = 3'b000,
		st_defer = 3'b001,
		st_acq = 3'b010,
		st_conv = 3'b011,
		st_recov = 3'b100
	} acs_state_e;

endpackage

// *** core/acs_top.sv ***
/*
 Conversion sequencer of a 12-bit successive-approximation converter with its registers.
 Assumes trigger pulses and the core result come from logic on clk_sys, pins do not.
*/
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ns
`include "acs_defs.svh"

module acs_top (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [3:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rd_data,
	input wire logic trig_ccp,
	input wire logic [3:0] capture_mode_field,
	input wire logic trig_charge_time_unit,
	input wire logic charge_time_trigger_bit,
	input wire logic trig_tmr1,
	input wire logic trig_rtc,
	output logic timer_clear,
	input wire logic [23:0] port_pins,
	output logic [23:0] port_read,
	input wire logic [11:0] core_result,
	output logic sample_en,
	output logic conv_start,
	output logic conv_bit_tick,
	output logic [4:0] pos_channel_select,
	output logic [2:0] neg_channel_select,
	output logic [1:0] pos_reference_select,
	output logic neg_reference_select,
	output logic conv_done_irq_flag
);

	// ----------------------------------------------------------------
	// Decoding functions
	// ----------------------------------------------------------------

	function automatic logic [7:0] tad_ratio(input logic [2:0] sel);
		logic [7:0] r;
		r = 8'h02;
		case (sel)
			3'b000: r = 8'h02;
			3'b100: r = 8'h04;
			3'b001: r = 8'h08;
			3'b101: r = 8'h10;
			3'b010: r = 8'h20;
			3'b110: r = 8'h40;
			default: r = 8'(`ACS_RC_TAD_CYC);
		endcase
		return r;
	endfunction

	function automatic logic [4:0] acq_tads(input logic [2:0] sel);
		logic [4:0] t;
		t = 5'h00;
		case (sel)
			3'b000: t = 5'h00;
			3'b001: t = 5'h02;
			3'b010: t = 5'h04;
			3'b011: t = 5'h06;
			3'b100: t = 5'h08;
			3'b101: t = 5'h0c;
			3'b110: t = 5'h10;
			default: t = 5'h14;
		endcase
		return t;
	endfunction

	// ----------------------------------------------------------------
	// Registers and state
	// ----------------------------------------------------------------

	acs_pkg::acs_state_e state_r, state_nxt;
	logic en_r, en_nxt;
	logic go_r, go_nxt;
	logic [4:0] chs_r, chs_nxt;
	logic [7:0] ctl_ref_r, ctl_ref_nxt;
	logic [7:0] ctl_tim_r, ctl_tim_nxt;
	logic [23:0] ana_r, ana_nxt;
	logic done_r, done_nxt;
	logic [7:0] ratio_r, ratio_nxt;
	logic [7:0] div_r, div_nxt;
	logic [4:0] cnt_r, cnt_nxt;
	logic [7:0] res_hi_r, res_hi_nxt;
	logic [7:0] res_lo_r, res_lo_nxt;
	logic [7:0] rd_data_r, rd_data_nxt;
	logic [23:0] pin_s1_r, pin_s2_r;
	logic [23:0] port_read_r;
	logic sample_en_r, conv_start_r, conv_bit_tick_r, timer_clear_r;

	logic wr_main, wr_stat;
	logic busy, tad_tick, restart;
	logic trig_hit, go_req, go_start, abort, conv_done;

	// ----------------------------------------------------------------
	// Request decoding
	// ----------------------------------------------------------------

	always_comb begin
		wr_main = wr_en && (addr == `ACS_OFS_CTL_MAIN);
		wr_stat = wr_en && (addr == `ACS_OFS_STATUS);
		busy = (state_r == acs_pkg::st_defer) || (state_r == acs_pkg::st_acq) ||
			(state_r == acs_pkg::st_conv);
		tad_tick = (div_r == (ratio_r - 8'h01));
		trig_hit = 1'b0;
		case (ctl_ref_r[7:6])
			`ACS_TRIG_CCP: trig_hit = trig_ccp && (capture_mode_field == `ACS_CCP_MODE_TRIG);
			`ACS_TRIG_CHARGE_TIME_UNIT: trig_hit = trig_charge_time_unit && charge_time_trigger_bit;
			`ACS_TRIG_TMR1: trig_hit = trig_tmr1;
			default: trig_hit = trig_rtc;
		endcase
		// A go written together with the enable is ignored: the module must already be on.
		go_req = en_r && ((wr_main && wr_data[`ACS_BIT_GO] && wr_data[`ACS_BIT_EN]) ||
			trig_hit);
		// Start ignores channel and pin direction settings.
		go_start = go_req && (state_r == acs_pkg::st_sample);
		abort = busy && wr_main &&
			(!wr_data[`ACS_BIT_GO] || !wr_data[`ACS_BIT_EN]);
		conv_done = (state_r == acs_pkg::st_conv) && tad_tick && !abort &&
			(cnt_r == 5'(`ACS_CONV_TADS - 1));
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			acs_pkg::st_sample: begin
				if (go_start) begin
					if (ctl_tim_r[5:3] == 3'b000) begin
						state_nxt = acs_pkg::st_defer;
					end else begin
						state_nxt = acs_pkg::st_acq;
					end
				end
			end
			acs_pkg::st_defer: begin
				if (abort) begin
					state_nxt = acs_pkg::st_recov;
				end else if (cnt_r == 5'(`ACS_INSTR_CYC - 1)) begin
					state_nxt = acs_pkg::st_conv;
				end
			end
			acs_pkg::st_acq: begin
				if (abort) begin
					state_nxt = acs_pkg::st_recov;
				end else if (tad_tick && (cnt_r == acq_tads(ctl_tim_r[5:3]) - 5'h01)) begin
					state_nxt = acs_pkg::st_conv;
				end
			end
			acs_pkg::st_conv: begin
				if (abort || conv_done) begin
					state_nxt = acs_pkg::st_recov;
				end
			end
			acs_pkg::st_recov: begin
				if (tad_tick && (cnt_r == 5'(`ACS_RECOV_TADS - 1))) begin
					state_nxt = acs_pkg::st_sample;
				end
			end
			default: state_nxt = acs_pkg::st_sample;
		endcase
		restart = (state_nxt != state_r);
		// The ratio is frozen once a start leaves the sampling state.
		ratio_nxt = (state_r == acs_pkg::st_sample) ? tad_ratio(ctl_tim_r[2:0]) :
			ratio_r;
		div_nxt = (restart || tad_tick) ? 8'h00 : div_r + 8'h01;
		if (restart) begin
			cnt_nxt = 5'h00;
		end else if ((state_r == acs_pkg::st_defer) || tad_tick) begin
			cnt_nxt = cnt_r + 5'h01;
		end else begin
			cnt_nxt = cnt_r;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_r <= acs_pkg::st_sample;
			ratio_r <= 8'h02;
			div_r <= 8'h00;
			cnt_r <= 5'h00;
		end else begin
			state_r <= state_nxt;
			ratio_r <= ratio_nxt;
			div_r <= div_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------

	always_comb begin
		en_nxt = wr_main ? wr_data[`ACS_BIT_EN] : en_r;
		chs_nxt = wr_main ? wr_data[6:2] : chs_r;
		ctl_ref_nxt = (wr_en && (addr == `ACS_OFS_CTL_REF)) ? wr_data : ctl_ref_r;
		ctl_tim_nxt = (wr_en && (addr == `ACS_OFS_CTL_TIM)) ? (wr_data & 8'hbf) : ctl_tim_r;
		ana_nxt = ana_r;
		if (wr_en && (addr == `ACS_OFS_ANA_LO)) begin
			ana_nxt[7:0] = wr_data;
		end
		if (wr_en && (addr == `ACS_OFS_ANA_MID)) begin
			ana_nxt[15:8] = wr_data;
		end
		if (wr_en && (addr == `ACS_OFS_ANA_HI)) begin
			ana_nxt[23:16] = wr_data;
		end
		// Go stays high through deferral, acquisition and conversion.
		if (conv_done || abort) begin
			go_nxt = 1'b0;
		end else if (go_start) begin
			go_nxt = 1'b1;
		end else begin
			go_nxt = go_r;
		end
		// A completion in the cycle of a clear keeps the flag set.
		if (conv_done) begin
			done_nxt = 1'b1;
		end else if (wr_stat && wr_data[`ACS_BIT_DONE]) begin
			done_nxt = 1'b0;
		end else begin
			done_nxt = done_r;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			en_r <= 1'b0;
			go_r <= 1'b0;
			chs_r <= 5'h00;
			ctl_ref_r <= `ACS_RST_CTL;
			ctl_tim_r <= `ACS_RST_CTL;
			ana_r <= `ACS_RST_ANA;
			done_r <= 1'b0;
		end else begin
			en_r <= en_nxt;
			go_r <= go_nxt;
			chs_r <= chs_nxt;
			ctl_ref_r <= ctl_ref_nxt;
			ctl_tim_r <= ctl_tim_nxt;
			ana_r <= ana_nxt;
			done_r <= done_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Result pair
	// ----------------------------------------------------------------

	// The pair has no reset so that its contents survive any reset.
	always_comb begin
		res_hi_nxt = res_hi_r;
		res_lo_nxt = res_lo_r;
		if (conv_done) begin
			if (ctl_tim_r[7]) begin
				res_hi_nxt = {4'h0, core_result[11:8]};
				res_lo_nxt = core_result[7:0];
			end else begin
				res_hi_nxt = core_result[11:4];
				res_lo_nxt = {core_result[3:0], 4'h0};
			end
		end else begin
			if (wr_en && (addr == `ACS_OFS_RES_HI)) begin
				res_hi_nxt = wr_data;
			end
			if (wr_en && (addr == `ACS_OFS_RES_LO)) begin
				res_lo_nxt = wr_data;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		res_hi_r <= res_hi_nxt;
		res_lo_r <= res_lo_nxt;
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------

	always_comb begin
		rd_data_nxt = 8'h00;
		if (rd_en) begin
			case (addr)
				`ACS_OFS_RES_HI: rd_data_nxt = res_hi_r;
				`ACS_OFS_RES_LO: rd_data_nxt = res_lo_r;
				`ACS_OFS_CTL_MAIN: rd_data_nxt = {1'b0, chs_r, go_r, en_r};
				`ACS_OFS_CTL_REF: rd_data_nxt = ctl_ref_r;
				`ACS_OFS_CTL_TIM: rd_data_nxt = ctl_tim_r;
				`ACS_OFS_ANA_LO: rd_data_nxt = ana_r[7:0];
				`ACS_OFS_ANA_MID: rd_data_nxt = ana_r[15:8];
				`ACS_OFS_ANA_HI: rd_data_nxt = ana_r[23:16];
				`ACS_OFS_STATUS: rd_data_nxt = {4'h0, state_r, done_r};
				default: rd_data_nxt = 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Pins and strobes to the core
	// ----------------------------------------------------------------

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rd_data_r <= 8'h00;
			pin_s1_r <= 24'h000000;
			pin_s2_r <= 24'h000000;
			port_read_r <= 24'h000000;
			sample_en_r <= 1'b0;
			conv_start_r <= 1'b0;
			conv_bit_tick_r <= 1'b0;
			timer_clear_r <= 1'b0;
		end else begin
			rd_data_r <= rd_data_nxt;
			pin_s1_r <= port_pins;
			pin_s2_r <= pin_s1_r;
			port_read_r <= pin_s2_r & ~ana_r;
			sample_en_r <= en_nxt && ((state_nxt == acs_pkg::st_sample) ||
				(state_nxt == acs_pkg::st_defer) || (state_nxt == acs_pkg::st_acq));
			conv_start_r <= restart && (state_nxt == acs_pkg::st_conv);
			conv_bit_tick_r <= tad_tick && (state_r == acs_pkg::st_conv) && !abort;
			// The timer clear does not depend on the module enable.
			timer_clear_r <= trig_ccp &&
				(capture_mode_field == `ACS_CCP_MODE_TRIG);
		end
	end

	assign rd_data = rd_data_r;
	assign port_read = port_read_r;
	assign sample_en = sample_en_r;
	assign conv_start = conv_start_r;
	assign conv_bit_tick = conv_bit_tick_r;
	assign timer_clear = timer_clear_r;
	assign pos_channel_select = chs_r;
	assign neg_channel_select = ctl_ref_r[2:0];
	assign pos_reference_select = ctl_ref_r[5:4];
	assign neg_reference_select = ctl_ref_r[3];
	assign conv_done_irq_flag = done_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------

	logic [4:0] hlp_ticks_r;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			hlp_ticks_r <= 5'h00;
		end else if (state_nxt != state_r) begin
			hlp_ticks_r <= 5'h00;
		end else if (tad_tick) begin
			hlp_ticks_r <= hlp_ticks_r + 5'h01;
		end
	end

	property p_conv_len;
		@(posedge clk_sys) disable iff (rst)
		conv_done |-> (hlp_ticks_r == 5'd13) && (ratio_r == $past(ratio_r));
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

	property p_ratio16;
		@(posedge clk_sys) disable iff (rst)
		(state_r == acs_pkg::st_sample) && (ctl_tim_r[2:0] == 3'b101) |=> (ratio_r == 8'd16);
	endproperty
	a_ratio16: assert property (p_ratio16) else $error("divide by sixteen wrong");

	property p_ratio_rc;
		@(posedge clk_sys) disable iff (rst)
		(state_r == acs_pkg::st_sample) && (ctl_tim_r[1:0] == 2'b11) |=> (ratio_r == 8'd200);
	endproperty
	a_ratio_rc: assert property (p_ratio_rc) else $error("rc period wrong");

	property p_port_zero;
		@(posedge clk_sys) disable iff (rst)
		(port_read_r & $past(ana_r)) == 24'h000000;
	endproperty
	a_port_zero: assert property (p_port_zero) else $error("analog pin reads high");

	property p_defer;
		@(posedge clk_sys) disable iff (rst)
		go_start && (ctl_tim_r[5:3] == 3'b000) && !wr_main |=>
			(state_r == acs_pkg::st_defer)[*4] ##1 (state_r != acs_pkg::st_defer);
	endproperty
	a_defer: assert property (p_defer) else $error("start deferral wrong");

	property p_acq4;
		@(posedge clk_sys) disable iff (rst)
		(state_r == acs_pkg::st_acq) && (state_nxt == acs_pkg::st_conv) &&
			(ctl_tim_r[5:3] == 3'b010) |-> (hlp_ticks_r == 5'd3) && tad_tick;
	endproperty
	a_acq4: assert property (p_acq4) else $error("acquisition length wrong");

	property p_abort;
		@(posedge clk_sys) disable iff (rst)
		abort |=> $stable(res_hi_r) && $stable(res_lo_r) && !go_r &&
			(state_r == acs_pkg::st_recov);
	endproperty
	a_abort: assert property (p_abort) else $error("abort wrote result");

	property p_recov;
		@(posedge clk_sys) disable iff (rst)
		(state_r == acs_pkg::st_recov) && (state_nxt == acs_pkg::st_sample) |->
			(hlp_ticks_r == 5'd1);
	endproperty
	a_recov: assert property (p_recov) else $error("recovery wait wrong");

	property p_trig_off;
		@(posedge clk_sys) disable iff (rst)
		trig_hit && !en_r |=> $stable(go_r);
	endproperty
	a_trig_off: assert property (p_trig_off) else $error("trigger acted while off");

	property p_trig_on;
		@(posedge clk_sys) disable iff (rst)
		trig_hit && en_r && (state_r == acs_pkg::st_sample) && !wr_main |=> go_r && busy;
	endproperty
	a_trig_on: assert property (p_trig_on) else $error("trigger start missed");

	property p_tclr;
		@(posedge clk_sys) disable iff (rst)
		trig_ccp && (capture_mode_field == 4'hb) |=> timer_clear_r;
	endproperty
	a_tclr: assert property (p_tclr) else $error("timer clear missed");

	property p_done;
		@(posedge clk_sys) disable iff (rst)
		conv_done |=> !go_r && done_r && (state_r == acs_pkg::st_recov);
	endproperty
	a_done: assert property (p_done) else $error("completion effects missing");

	property p_go_busy;
		@(posedge clk_sys) disable iff (rst)
		busy |-> go_r;
	endproperty
	a_go_busy: assert property (p_go_busy) else $error("go low while busy");

	c_done: cover property (@(posedge clk_sys) disable iff (rst) conv_done);
	c_abort: cover property (@(posedge clk_sys) disable iff (rst) abort);
	c_trig: cover property (@(posedge clk_sys) disable iff (rst) trig_hit && go_start);
	c_acq: cover property (@(posedge clk_sys) disable iff (rst)
		(state_r == acs_pkg::st_acq) ##1 (state_r == acs_pkg::st_conv));

endmodule
